// ### tw_defs.vh
`ifndef TW_DEFS_VH
`define TW_DEFS_VH

// Bus state codes
`define TW_BUS_UNKNOWN 2'h0
`define TW_BUS_IDLE 2'h1
`define TW_BUS_OWNER 2'h2
`define TW_BUS_BUSY 2'h3

// Command codes
`define TW_OP_START 2'h0
`define TW_OP_WRITE 2'h1
`define TW_OP_READ 2'h2
`define TW_OP_STOP 2'h3

// Timing
`define TW_CLK_MHZ 100
`define TW_LOW_NS 4700
`define TW_HIGH_NS 4000
`define TW_TOUT_NS 50000
`define TW_LOW_CYC ((`TW_LOW_NS * `TW_CLK_MHZ + 999) / 1000)
`define TW_HIGH_CYC ((`TW_HIGH_NS * `TW_CLK_MHZ + 999) / 1000)
`define TW_TOUT_CYC ((`TW_TOUT_NS * `TW_CLK_MHZ) / 1000)
`define TW_FILT 3

`endif

// ### tw_sync.v
module tw_sync #(
    parameter FILT = 3
) (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire pin,
    output reg level
);
    reg s1;
    reg s2;
    reg [3:0] cnt;

    // Lines idle high, so the filtered level resets high
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            cnt <= 4'h0;
            level <= 1'b1;
        end else if (ce) begin
            s1 <= pin;
            s2 <= s1;
            if (s2 != level) begin
                // Spikes shorter than FILT cycles never reach the level
                if (cnt == FILT[3:0] - 4'h1) begin
                    level <= s2;
                    cnt <= 4'h0;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end else begin
                cnt <= 4'h0;
            end
        end
    end
endmodule // tw_sync

// ### tw_master.v
`include "tw_defs.vh"

// Notes on behaviour
// - A transaction runs from START to STOP; repeated STARTs stay inside it.
// - Write: START, address with direction low, data bytes each acknowledged by slave.
// - A write with no data ends with STOP right after the address.
// - On a NACK to written data the master stops and ends the transaction.
// - Read: START, address with direction high; continue only if address is acknowledged.
// - Master acknowledges read bytes and NACKs the last one before STOP.
// - Read and write phases may be chained by repeated STARTs without STOP.
// - Clock is stretched only by holding SCL after it is already seen low.
// - While SCL is held low by another party, bit timing waits for high.
// - A transaction starts only once the bus monitor says idle.
// - Driving SDA high but seeing low loses arbitration; release until STOP.
// - Low timer restarts on each SCL fall; high timer starts on SCL high.
// - START is SDA falling with SCL high; STOP is SDA rising with SCL high.
module tw_master #(
    parameter [15:0] LOW_CYC = `TW_LOW_CYC,
    parameter [15:0] HIGH_CYC = `TW_HIGH_CYC,
    parameter [15:0] TOUT_CYC = `TW_TOUT_CYC,
    parameter FILT = `TW_FILT
) (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire enable,
    input wire tout_en,
    input wire force_idle,
    input wire cmd_valid,
    input wire [1:0] cmd_op,
    input wire [7:0] cmd_data,
    input wire cmd_nack,
    output reg cmd_ready,
    output reg rsp_valid,
    output reg [7:0] rsp_data,
    output reg rsp_nack,
    output reg rsp_lost,
    output reg rsp_err,
    output reg [1:0] bus_state,
    input wire scl_i,
    output reg scl_o,
    output reg scl_oe,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe
);
    localparam [5:0] E_IDLE = 6'h01;
    localparam [5:0] E_WAITBUS = 6'h02;
    localparam [5:0] E_LOW = 6'h04;
    localparam [5:0] E_RISE = 6'h08;
    localparam [5:0] E_HIGH = 6'h10;
    localparam [5:0] E_FIN = 6'h20;

    wire scl_s;
    wire sda_s;
    reg scl_d;
    reg sda_d;
    reg [15:0] tout;
    reg [5:0] state;
    reg [1:0] op;
    reg [3:0] bitn;
    reg half;
    reg [15:0] cnt;
    reg [7:0] shreg;
    reg tx_nack;
    reg got_nack;
    reg lost;
    reg lost_pulse;
    reg err;
    reg stop_pend;
    reg addr_phase;
    reg dir_read;
    reg gen_start;

    tw_sync #(.FILT(FILT)) u_scl_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .pin(scl_i),
        .level(scl_s)
    );
    tw_sync #(.FILT(FILT)) u_sda_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .pin(sda_i),
        .level(sda_s)
    );

    wire start_det = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
    wire tout_exp = tout_en & (tout == TOUT_CYC);
    wire low_end = (cnt == LOW_CYC - 16'h1);
    wire high_end = (cnt == HIGH_CYC - 16'h1) | ~scl_s;
    // Bits where we leave SDA released and expect to read it high
    wire tx_high = ~sda_oe & (((op == `TW_OP_WRITE) & ~bitn[3]) |
        ((op == `TW_OP_READ) & bitn[3]) | ((op == `TW_OP_START) & ~half));

    // Own bus monitor
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            tout <= 16'h0;
            bus_state <= `TW_BUS_UNKNOWN;
        end else if (ce) begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            if (!scl_s || !sda_s) begin
                tout <= 16'h0;
            end else if (tout != TOUT_CYC) begin
                tout <= tout + 16'h1;
            end
            if (!enable) begin
                bus_state <= `TW_BUS_UNKNOWN;
            end else begin
                case (bus_state)
                    `TW_BUS_UNKNOWN: begin
                        if (force_idle || stop_det || tout_exp) begin
                            bus_state <= `TW_BUS_IDLE;
                        end
                    end
                    `TW_BUS_IDLE: begin
                        if (start_det) begin
                            bus_state <= gen_start ? `TW_BUS_OWNER : `TW_BUS_BUSY;
                        end
                    end
                    `TW_BUS_OWNER: begin
                        if (lost_pulse) begin
                            bus_state <= `TW_BUS_BUSY;
                        end else if (stop_det) begin
                            bus_state <= `TW_BUS_IDLE;
                        end
                    end
                    `TW_BUS_BUSY: begin
                        if (stop_det || tout_exp) begin
                            bus_state <= `TW_BUS_IDLE;
                        end
                    end
                    default: begin
                        bus_state <= `TW_BUS_UNKNOWN;
                    end
                endcase
            end
        end
    end

    // Bit engine
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= E_IDLE;
            op <= `TW_OP_START;
            bitn <= 4'h0;
            half <= 1'b0;
            cnt <= 16'h0;
            shreg <= 8'h00;
            tx_nack <= 1'b0;
            got_nack <= 1'b0;
            lost <= 1'b0;
            lost_pulse <= 1'b0;
            err <= 1'b0;
            stop_pend <= 1'b0;
            addr_phase <= 1'b0;
            dir_read <= 1'b0;
            gen_start <= 1'b0;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_nack <= 1'b0;
            rsp_lost <= 1'b0;
            rsp_err <= 1'b0;
            scl_o <= 1'b0;
            scl_oe <= 1'b0;
            sda_o <= 1'b0;
            sda_oe <= 1'b0;
        end else if (ce) begin
            rsp_valid <= 1'b0;
            lost_pulse <= 1'b0;
            if (!enable) begin
                state <= E_IDLE;
                cmd_ready <= 1'b0;
                scl_oe <= 1'b0;
                sda_oe <= 1'b0;
                stop_pend <= 1'b0;
                gen_start <= 1'b0;
                lost <= 1'b0;
                err <= 1'b0;
            end else begin
                case (state)
                    E_IDLE: begin
                        cmd_ready <= 1'b1;
                        if (cmd_valid && cmd_ready) begin
                            cmd_ready <= 1'b0;
                            op <= cmd_op;
                            bitn <= 4'h0;
                            half <= 1'b0;
                            cnt <= 16'h0;
                            got_nack <= 1'b0;
                            tx_nack <= cmd_nack;
                            shreg <= cmd_data;
                            if (cmd_op == `TW_OP_START) begin
                                addr_phase <= 1'b1;
                                if (bus_state == `TW_BUS_OWNER) begin
                                    state <= E_LOW;
                                end else begin
                                    state <= E_WAITBUS;
                                end
                            end else if (bus_state != `TW_BUS_OWNER) begin
                                err <= 1'b1;
                                state <= E_FIN;
                            end else if (cmd_op == `TW_OP_WRITE) begin
                                if (!addr_phase && dir_read) begin
                                    err <= 1'b1;
                                    state <= E_FIN;
                                end else begin
                                    if (addr_phase) begin
                                        dir_read <= cmd_data[0];
                                    end
                                    addr_phase <= 1'b0;
                                    state <= E_LOW;
                                end
                            end else if (cmd_op == `TW_OP_READ) begin
                                if (addr_phase || !dir_read) begin
                                    err <= 1'b1;
                                    state <= E_FIN;
                                end else begin
                                    state <= E_LOW;
                                end
                            end else begin
                                state <= E_LOW;
                            end
                        end
                    end
                    E_WAITBUS: begin
                        if (bus_state == `TW_BUS_IDLE && scl_s && sda_s) begin
                            cnt <= 16'h0;
                            state <= E_HIGH;
                        end
                    end
                    E_LOW: begin
                        if (cnt == 16'h0) begin
                            case (op)
                                `TW_OP_START: sda_oe <= 1'b0;
                                `TW_OP_STOP: sda_oe <= 1'b1;
                                `TW_OP_WRITE: sda_oe <= bitn[3] ? 1'b0 : ~shreg[7];
                                default: sda_oe <= bitn[3] ? ~tx_nack : 1'b0;
                            endcase
                        end
                        if (low_end) begin
                            scl_oe <= 1'b0;
                            state <= E_RISE;
                        end else begin
                            cnt <= cnt + 16'h1;
                        end
                    end
                    E_RISE: begin
                        cnt <= 16'h0;
                        if (scl_s) begin
                            state <= E_HIGH;
                        end
                    end
                    E_HIGH: begin
                        cnt <= cnt + 16'h1;
                        if (tx_high && !sda_s) begin
                            // Drop both lines at once; the bus belongs to another master
                            sda_oe <= 1'b0;
                            scl_oe <= 1'b0;
                            lost <= 1'b1;
                            lost_pulse <= 1'b1;
                            stop_pend <= 1'b0;
                            state <= E_FIN;
                        end else begin
                            if (cnt == 16'h0 && (op == `TW_OP_WRITE || op == `TW_OP_READ)) begin
                                if (bitn[3]) begin
                                    got_nack <= sda_s;
                                    stop_pend <= (op == `TW_OP_WRITE) ? sda_s : tx_nack;
                                end else begin
                                    shreg <= {shreg[6:0], sda_s};
                                end
                            end
                            if (high_end) begin
                                cnt <= 16'h0;
                                if (op == `TW_OP_START && !half) begin
                                    sda_oe <= 1'b1;
                                    gen_start <= 1'b1;
                                    half <= 1'b1;
                                end else if (op == `TW_OP_STOP && !half) begin
                                    sda_oe <= 1'b0;
                                    half <= 1'b1;
                                end else if (op == `TW_OP_STOP) begin
                                    state <= E_FIN;
                                end else begin
                                    scl_oe <= 1'b1;
                                    if (op == `TW_OP_START || bitn[3]) begin
                                        state <= E_FIN;
                                    end else begin
                                        bitn <= bitn + 4'h1;
                                        state <= E_LOW;
                                    end
                                end
                            end
                        end
                    end
                    E_FIN: begin
                        if (stop_pend) begin
                            // NACKed write or last read byte ends the transaction
                            stop_pend <= 1'b0;
                            rsp_data <= shreg;
                            rsp_nack <= got_nack;
                            op <= `TW_OP_STOP;
                            half <= 1'b0;
                            cnt <= 16'h0;
                            state <= E_LOW;
                        end else begin
                            if (op != `TW_OP_STOP) begin
                                rsp_data <= shreg;
                                rsp_nack <= got_nack;
                            end
                            rsp_lost <= lost;
                            rsp_err <= err;
                            rsp_valid <= 1'b1;
                            lost <= 1'b0;
                            err <= 1'b0;
                            gen_start <= 1'b0;
                            // SCL stays held after a byte: stretching an already low clock
                            state <= E_IDLE;
                        end
                    end
                    default: begin
                        state <= E_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // tw_master

// ### tw_master_assertions.sv
`include "tw_defs.vh"

module tw_master_assertions #(
    parameter [15:0] LOW_CYC = 16'h0008
) (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire enable,
    input wire rsp_valid,
    input wire rsp_nack,
    input wire rsp_lost,
    input wire rsp_err,
    input wire [1:0] bus_state,
    input wire scl_oe,
    input wire sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [15:0] low_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Length of the current low phase that we drive
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
            low_cnt <= 16'h0000;
        else
            low_cnt <= scl_oe ? low_cnt + 16'h0001 : 16'h0000;

    a_disable_unknown: assert property (!enable && ce |=> bus_state == `TW_BUS_UNKNOWN)
        else $error("state kept after disable");
    a_unknown_exit: assert property (bus_state == `TW_BUS_UNKNOWN |=>
        bus_state == `TW_BUS_UNKNOWN || bus_state == `TW_BUS_IDLE) else $error("bad exit");
    a_owner_entry: assert property (bus_state == `TW_BUS_OWNER &&
        $past(bus_state) != `TW_BUS_OWNER |-> $past(bus_state) == `TW_BUS_IDLE)
        else $error("owner not entered from idle");
    a_lost_busy: assert property (rsp_valid && rsp_lost |-> bus_state == `TW_BUS_BUSY)
        else $error("lost without busy");
    a_nack_ends: assert property (rsp_valid && rsp_nack && !rsp_lost && !rsp_err |->
        bus_state == `TW_BUS_IDLE) else $error("nack did not end transfer");
    a_busy_hands_off: assert property (bus_state == `TW_BUS_BUSY &&
        $past(bus_state) == `TW_BUS_BUSY |-> !scl_oe && !sda_oe) else $error("drive in busy");
    a_unknown_quiet: assert property (bus_state == `TW_BUS_UNKNOWN &&
        $past(bus_state) == `TW_BUS_UNKNOWN |-> !scl_oe && !sda_oe) else $error("drive in unknown");
    a_low_period: assert property ($fell(scl_oe) && $past(enable) |->
        low_cnt >= LOW_CYC - 16'h0001) else $error("low phase too short");
endmodule // tw_master_assertions

bind tw_master tw_master_assertions #(.LOW_CYC(LOW_CYC)) tw_master_assertions_i (
    .clk(clk), .rst_n(rst_n), .ce(ce), .enable(enable), .rsp_valid(rsp_valid),
    .rsp_nack(rsp_nack), .rsp_lost(rsp_lost), .rsp_err(rsp_err), .bus_state(bus_state),
    .scl_oe(scl_oe), .sda_oe(sda_oe));

// ### tw_bus_peer.sv
module tw_bus_peer #(
    parameter [6:0] ADDR = 7'h2a,
    parameter [7:0] NACK_BYTE = 8'hee,
    parameter [7:0] TX_BYTE = 8'hc3
) (
    input wire clk,
    input wire rst_n,
    input wire scl,
    input wire sda,
    input wire [7:0] stretch,
    output reg scl_pull,
    output reg sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    reg scl_q, sda_q, sel, rd, addr_ph, mnack;
    reg [3:0] bits;
    reg [7:0] sh, hold;
    wire xmit = sel && rd && !mnack;
    wire [2:0] idx = (bits == 4'h9) ? 3'h0 : bits[2:0];

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {scl_q, sda_q, sel, rd, addr_ph, mnack, scl_pull, sda_pull} <= 8'hc0;
            bits <= 4'h0;
            sh <= 8'h00;
            hold <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (hold != 8'h00)
                hold <= hold - 8'h01;
            else
                scl_pull <= 1'b0;
            if (scl && scl_q && sda_q && !sda) begin
                bits <= 4'h0;
                addr_ph <= 1'b1;
                sel <= 1'b0;
                mnack <= 1'b0;
                sda_pull <= 1'b0;
            end else if (scl && scl_q && !sda_q && sda) begin
                sel <= 1'b0;
                sda_pull <= 1'b0;
            end else if (scl && !scl_q) begin
                if (bits == 4'h8)
                    mnack <= sda;
                else
                    sh <= {sh[6:0], sda};
                bits <= bits + 4'h1;
            end else if (!scl && scl_q) begin
                if (bits == 4'h8) begin
                    // Line already low here, so holding it never makes an edge
                    hold <= stretch;
                    scl_pull <= (stretch != 8'h00);
                    if (addr_ph) begin
                        sel <= (sh[7:1] == ADDR);
                        rd <= sh[0];
                        sda_pull <= (sh[7:1] == ADDR);
                    end else begin
                        sda_pull <= sel && !rd && (sh != NACK_BYTE);
                    end
                end else begin
                    if (bits == 4'h9) begin
                        bits <= 4'h0;
                        addr_ph <= 1'b0;
                    end
                    sda_pull <= xmit && !TX_BYTE[3'h7 - idx];
                end
            end
        end
    end
endmodule // tw_bus_peer

// ### tw_master_test.sv
`include "tw_defs.vh"

module tw_master_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam integer LIM = 20000;
    reg clk, rst_n, enable, tout_en, force_idle, cmd_valid, cmd_nack, tb_scl, tb_sda;
    reg [1:0] cmd_op;
    reg [7:0] cmd_data, stretch;
    wire cmd_ready, rsp_valid, rsp_nack, rsp_lost, rsp_err, scl_o, scl_oe, sda_o, sda_oe;
    wire p_scl, p_sda, scl_w, sda_w;
    wire [7:0] rsp_data;
    wire [1:0] bus_state;
    integer bad_count, cmp_count;

    // Wired-AND lines with pull-ups
    assign scl_w = ~((scl_oe & ~scl_o) | p_scl | tb_scl);
    assign sda_w = ~((sda_oe & ~sda_o) | p_sda | tb_sda);

    tw_master #(.LOW_CYC(16'h0008), .HIGH_CYC(16'h0008), .TOUT_CYC(16'h0028)) tw_master_i (
        .clk(clk), .rst_n(rst_n), .ce(1'b1), .enable(enable), .tout_en(tout_en),
        .force_idle(force_idle), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
        .cmd_nack(cmd_nack), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_nack(rsp_nack), .rsp_lost(rsp_lost), .rsp_err(rsp_err), .bus_state(bus_state),
        .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe(sda_oe));
    tw_bus_peer tw_bus_peer_i (.clk(clk), .rst_n(rst_n), .scl(scl_w), .sda(sda_w),
        .stretch(stretch), .scl_pull(p_scl), .sda_pull(p_sda));

    task complete_run;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
            if (bad_count == 0 && cmp_count > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    task check(input [7:0] seen, input [7:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task check_rsp(input [2:0] f);
        check({5'h00, rsp_err, rsp_lost, rsp_nack}, {5'h00, f});
    endtask

    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask

    task wait_state(input [1:0] s, input integer lim);
        integer k;
        begin
            k = 0;
            while (bus_state !== s && k < lim) begin
                @(posedge clk);
                k = k + 1;
            end
            check({6'h00, bus_state}, {6'h00, s});
            if (lim > 0 && k >= lim)
                complete_run;
        end
    endtask

    // Holds valid until the edge that takes it, then waits for the answer
    task cmd(input [1:0] op, input [7:0] d, input n);
        integer k;
        begin
            k = 0;
            @(posedge clk);
            while (cmd_ready !== 1'b1 && k < LIM) begin
                @(posedge clk);
                k = k + 1;
            end
            cmd_op <= op;
            cmd_data <= d;
            cmd_nack <= n;
            cmd_valid <= 1'b1;
            @(posedge clk);
            cmd_valid <= 1'b0;
            while (rsp_valid !== 1'b1 && k < LIM) begin
                @(posedge clk);
                k = k + 1;
            end
            if (k >= LIM) begin
                check(8'h00, 8'h01);
                complete_run;
            end
        end
    endtask

    task t_states;
        begin
            wait_state(`TW_BUS_UNKNOWN, 0);
            force_idle <= 1'b1;
            wait_state(`TW_BUS_IDLE, 20);
            force_idle <= 1'b0;
            enable <= 1'b0;
            wait_state(`TW_BUS_UNKNOWN, 5);
            enable <= 1'b1;
            tout_en <= 1'b1;
            wait_state(`TW_BUS_IDLE, 100);
            tout_en <= 1'b0;
            cmd(`TW_OP_WRITE, 8'h54, 1'b0);
            check_rsp(3'h4);
        end
    endtask

    task t_write;
        begin
            stretch <= 8'h1e;
            cmd(`TW_OP_START, 8'h00, 1'b0);
            wait_state(`TW_BUS_OWNER, 0);
            cmd(`TW_OP_WRITE, 8'h54, 1'b0);
            check_rsp(3'h0);
            cmd(`TW_OP_WRITE, 8'h5a, 1'b0);
            check(rsp_data, 8'h5a);
            cmd(`TW_OP_WRITE, 8'hee, 1'b0);
            check_rsp(3'h1);
            wait_state(`TW_BUS_IDLE, 0);
            stretch <= 8'h00;
            cmd(`TW_OP_START, 8'h00, 1'b0);
            cmd(`TW_OP_WRITE, 8'h54, 1'b0);
            cmd(`TW_OP_STOP, 8'h00, 1'b0);
            wait_state(`TW_BUS_IDLE, 0);
        end
    endtask

    task t_read;
        begin
            cmd(`TW_OP_START, 8'h00, 1'b0);
            cmd(`TW_OP_WRITE, 8'h54, 1'b0);
            cmd(`TW_OP_START, 8'h00, 1'b0);
            wait_state(`TW_BUS_OWNER, 0);
            cmd(`TW_OP_READ, 8'h00, 1'b0);
            check_rsp(3'h4);
            cmd(`TW_OP_WRITE, 8'h55, 1'b0);
            check_rsp(3'h0);
            cmd(`TW_OP_READ, 8'h00, 1'b0);
            check(rsp_data, 8'hc3);
            cmd(`TW_OP_READ, 8'h00, 1'b1);
            check_rsp(3'h1);
            wait_state(`TW_BUS_IDLE, 0);
            cmd(`TW_OP_START, 8'h00, 1'b0);
            cmd(`TW_OP_WRITE, 8'h41, 1'b0);
            check_rsp(3'h1);
            wait_state(`TW_BUS_IDLE, 0);
        end
    endtask

    // Another master runs a short transfer at the 80 ns link rate, then falls silent
    task t_foreign;
        begin
            tb_sda <= 1'b1;
            tick(4);
            tb_scl <= 1'b1;
            wait_state(`TW_BUS_BUSY, 10);
            // A START asked for now has to wait for the bus
            cmd_op <= `TW_OP_START;
            cmd_valid <= 1'b1;
            tick(1);
            cmd_valid <= 1'b0;
            repeat (2) begin
                tb_scl <= 1'b0;
                tick(4);
                tb_scl <= 1'b1;
                tick(4);
            end
            check({7'h00, cmd_ready}, 8'h00);
            check({6'h00, scl_oe, sda_oe}, 8'h00);
            // SDA let go under a low SCL: no STOP, only the timeout frees the bus
            tb_sda <= 1'b0;
            tick(4);
            tb_scl <= 1'b0;
            tout_en <= 1'b1;
            wait_state(`TW_BUS_IDLE, 80);
            tout_en <= 1'b0;
            wait_state(`TW_BUS_OWNER, 40);
            cmd(`TW_OP_STOP, 8'h00, 1'b0);
            check_rsp(3'h0);
            wait_state(`TW_BUS_IDLE, 0);
        end
    endtask

    task t_arb;
        begin
            cmd(`TW_OP_START, 8'h00, 1'b0);
            tb_sda <= 1'b1;
            cmd(`TW_OP_WRITE, 8'hff, 1'b0);
            check_rsp(3'h2);
            wait_state(`TW_BUS_BUSY, 0);
            tb_sda <= 1'b0;
            wait_state(`TW_BUS_IDLE, 20);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        {rst_n, tout_en, force_idle, cmd_valid, cmd_nack, tb_scl, tb_sda} = 7'h00;
        enable = 1'b1;
        cmd_op = 2'h0;
        cmd_data = 8'h00;
        stretch = 8'h00;
        bad_count = 0;
        cmp_count = 0;
        tick(2);
        rst_n <= 1'b1;
        tick(2);
        t_states;
        t_write;
        t_read;
        t_foreign;
        t_arb;
        complete_run;
    end
endmodule // tw_master_test
